// ---- hw/tws_map.vh ----
// register map, field positions and codes of the two-wire slave engine
// assumes: classic wishbone slave, 32-bit data, byte addresses
// What this block does
// RULE1 - wait start, match address, ack or ignore
// RULE2 - matching or general call address sets address flag
// RULE3 - stop right after start sets bus error
// RULE4 - direction bit kept in readable flag
// RULE5 - master read: stretch clock, request byte
// RULE6 - address nack returns to waiting for start
// RULE7 - master write: stretch, then data, restart or stop
// RULE8 - collision: flag, release outputs, accept start
// RULE9 - stop sets address flag with stop indication
// RULE10 - written byte sets data flag, then ack/nack
// RULE11 - read: send data register byte, flag when done
// RULE12 - master nack ends sending, await stop/restart
// RULE13 - data register locked unless clock held
// RULE14 - after master ack bit set data and hold flags
// RULE15 - full byte received sets data and hold flags
// RULE16 - auto-ack mode: data read triggers bus action
// RULE17 - data register access clears flags and hold
// RULE18 - mask mode: mask bit one forces match
// RULE19 - second address mode: match either address
// RULE20 - general call is seven zero address bits
`ifndef TWS_MAP_VH
`define TWS_MAP_VH
`define TWS_OFS_CTRL_A 4'h0
`define TWS_OFS_CTRL_B 4'h1
`define TWS_OFS_STATUS 4'h2
`define TWS_OFS_ADDR 4'h3
`define TWS_OFS_DATA 4'h4
`define TWS_OFS_MASK 4'h5
// control a bits
`define TWS_CA_ENABLE 0
`define TWS_CA_AUTO 1
// control b bits
`define TWS_CB_ACK_ACT 0
`define TWS_CB_CMD_LO 1
`define TWS_CB_CMD_HI 2
`define TWS_CMD_NONE 2'h0
`define TWS_CMD_DONE 2'h2
`define TWS_CMD_RESP 2'h3
// status bits
`define TWS_ST_DATA_IF 0
`define TWS_ST_ADDR_IF 1
`define TWS_ST_HOLD 2
`define TWS_ST_DIR 3
`define TWS_ST_COLL 4
`define TWS_ST_BUS_ERR 5
`define TWS_ST_IS_ADDR 6
`define TWS_ST_BUSY 7
`define TWS_RST_BYTE 8'h00
`define TWS_BYTE_BITS 4'h8
`define TWS_GCALL 7'h00
`endif

// ---- hw/tws_slave.v ----
// two-wire slave engine with classic wishbone register slave
// assumes: scl and sda are open-drain, levels worked out outside
`timescale 1ns/1ps
`include "tws_map.vh"
module tws_slave (
  input wire I_CORE_CLK,
  input wire I_RESET,
  input wire I_CE,
  input wire I_WB_CYC,
  input wire I_WB_STB,
  input wire I_WB_WE,
  input wire [3:0] I_WB_SEL,
  input wire [31:0] I_WB_ADR,
  input wire [31:0] I_WB_DAT,
  output reg [31:0] O_WB_DAT,
  output reg O_WB_ACK,
  input wire I_SCL,
  output wire O_SCL,
  output wire O_SCL_OE,
  input wire I_SDA,
  output wire O_SDA,
  output wire O_SDA_OE
);
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_ACK = 3'h2;
  localparam ST_RX = 3'h3;
  localparam ST_TX = 3'h4;
  localparam ST_MACK = 3'h5;
  localparam ST_WAIT = 3'h6;

  wire scl_s;
  wire sda_s;
  tws_sync u_scl (.i_clk(I_CORE_CLK), .i_reset(I_RESET), .i_ce(I_CE),
    .i_pin(I_SCL), .o_level(scl_s));
  tws_sync u_sda (.i_clk(I_CORE_CLK), .i_reset(I_RESET), .i_ce(I_CE),
    .i_pin(I_SDA), .o_level(sda_s));

  reg scl_q, sda_q;
  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start_ev = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_ev = scl_s & scl_q & ~sda_q & sda_s;

  reg [7:0] ctrl_a_q, ctrl_b_q, addr_q, mask_q, data_q, shift_q;
  reg [2:0] state_q;
  reg [3:0] cnt_q;
  reg data_if_q, addr_if_q, hold_q, dir_q, coll_q, berr_q, is_addr_q;
  reg ack_out_q, drive_q, just_start_q, ack_phase_q;
  reg [1:0] tail_q;

  // [RULE18] [RULE19] [RULE20]
  function addr_hit;
    input [6:0] a;
    input [7:0] prim;
    input [7:0] msk;
    begin
      if (a == `TWS_GCALL)
        addr_hit = 1'b1;
      else if (msk[0])
        addr_hit = (a == prim[7:1]) || (a == msk[7:1]);
      else
        addr_hit = ((a ^ prim[7:1]) & ~msk[7:1]) == 7'h00;
    end
  endfunction

  wire enabled = ctrl_a_q[`TWS_CA_ENABLE];
  wire busy = (state_q != ST_IDLE) && !hold_q;
  wire wb_req = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
  wire [3:0] wb_idx = I_WB_ADR[5:2];
  wire wb_wr = wb_req & I_WB_WE & I_WB_SEL[0];
  wire wb_rd = wb_req & ~I_WB_WE;
  // locked during a byte transfer
  wire data_ok = hold_q & ~coll_q; // [RULE13]
  wire data_wr = wb_wr && wb_idx == `TWS_OFS_DATA && data_ok;
  wire data_rd = wb_rd && wb_idx == `TWS_OFS_DATA && data_ok;
  wire [1:0] cmd = I_WB_DAT[`TWS_CB_CMD_HI:`TWS_CB_CMD_LO];
  wire cmd_wr = wb_wr && wb_idx == `TWS_OFS_CTRL_B;
  wire auto_go = data_rd && ctrl_a_q[`TWS_CA_AUTO]; // [RULE16]
  wire resume = (cmd_wr && cmd == `TWS_CMD_RESP) || auto_go || data_wr;
  wire resp_ack = auto_go ? ~ctrl_b_q[`TWS_CB_ACK_ACT] : ~I_WB_DAT[`TWS_CB_ACK_ACT];
  wire [7:0] status = {busy, is_addr_q, berr_q, coll_q, dir_q, hold_q, addr_if_q, data_if_q};

  assign O_SCL = 1'b0;
  // hold kept two more cycles so sda settles before scl is let go
  assign O_SCL_OE = (hold_q | (|tail_q)) & ~coll_q; // [RULE5] [RULE7]
  assign O_SDA = 1'b0;
  assign O_SDA_OE = drive_q & ~coll_q; // [RULE8]

  always @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 32'h0000_0000;
    end else if (I_CE) begin
      O_WB_ACK <= wb_req;
      if (wb_rd) begin
        case (wb_idx)
          `TWS_OFS_CTRL_A: O_WB_DAT <= {24'h00_0000, ctrl_a_q};
          `TWS_OFS_CTRL_B: O_WB_DAT <= {24'h00_0000, ctrl_b_q};
          `TWS_OFS_STATUS: O_WB_DAT <= {24'h00_0000, status};
          `TWS_OFS_ADDR: O_WB_DAT <= {24'h00_0000, addr_q};
          `TWS_OFS_DATA: O_WB_DAT <= {24'h00_0000, data_ok ? data_q : `TWS_RST_BYTE};
          `TWS_OFS_MASK: O_WB_DAT <= {24'h00_0000, mask_q};
          default: O_WB_DAT <= 32'h0000_0000;
        endcase
      end
    end
  end

  always @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      ctrl_a_q <= `TWS_RST_BYTE;
      ctrl_b_q <= `TWS_RST_BYTE;
      addr_q <= `TWS_RST_BYTE;
      mask_q <= `TWS_RST_BYTE;
      data_q <= `TWS_RST_BYTE;
      shift_q <= `TWS_RST_BYTE;
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      data_if_q <= 1'b0;
      addr_if_q <= 1'b0;
      hold_q <= 1'b0;
      dir_q <= 1'b0;
      coll_q <= 1'b0;
      berr_q <= 1'b0;
      is_addr_q <= 1'b0;
      ack_out_q <= 1'b0;
      drive_q <= 1'b0;
      just_start_q <= 1'b0;
      ack_phase_q <= 1'b0;
      tail_q <= 2'h0;
    end else if (I_CE) begin
      scl_q <= scl_s;
      tail_q <= {tail_q[0], hold_q};
      sda_q <= sda_s;
      if (wb_wr) begin
        case (wb_idx)
          `TWS_OFS_CTRL_A: ctrl_a_q <= I_WB_DAT[7:0];
          `TWS_OFS_CTRL_B: ctrl_b_q <= {7'h00, I_WB_DAT[`TWS_CB_ACK_ACT]};
          `TWS_OFS_ADDR: addr_q <= I_WB_DAT[7:0];
          `TWS_OFS_MASK: mask_q <= I_WB_DAT[7:0];
          `TWS_OFS_STATUS: begin
            // write one to clear error flags
            if (I_WB_DAT[`TWS_ST_COLL]) coll_q <= 1'b0;
            if (I_WB_DAT[`TWS_ST_BUS_ERR]) berr_q <= 1'b0;
          end
          default: ;
        endcase
      end
      if (data_wr)
        data_q <= I_WB_DAT[7:0];
      // clears first; bus events below override, so a set wins
      if (data_wr || data_rd || (cmd_wr && cmd != `TWS_CMD_NONE)) begin
        data_if_q <= 1'b0; // [RULE17]
        addr_if_q <= 1'b0;
        hold_q <= 1'b0;
      end
      if (resume && hold_q) begin
        if (state_q == ST_ACK || state_q == ST_MACK) begin
          ack_out_q <= resp_ack;
        end
        if (cmd_wr && cmd == `TWS_CMD_DONE)
          state_q <= ST_WAIT;
      end
      // a nack we cannot see on the wire is a collision
      if (scl_rise && ack_phase_q && !ack_out_q && !sda_s && state_q == ST_ACK) begin
        coll_q <= 1'b1; // [RULE8]
        state_q <= ST_WAIT;
        drive_q <= 1'b0;
        ack_phase_q <= 1'b0;
      end
      if (!enabled) begin
        state_q <= ST_IDLE;
        drive_q <= 1'b0;
        hold_q <= 1'b0;
      end else if (start_ev) begin
        state_q <= ST_ADDR; // [RULE1] [RULE8]
        cnt_q <= 4'h0;
        drive_q <= 1'b0;
        ack_phase_q <= 1'b0;
        just_start_q <= 1'b1;
      end else if (stop_ev) begin
        if (just_start_q)
          berr_q <= 1'b1; // [RULE3]
        else if (state_q != ST_IDLE) begin
          addr_if_q <= 1'b1; // [RULE9]
          is_addr_q <= 1'b0;
        end
        state_q <= ST_IDLE;
        drive_q <= 1'b0;
        just_start_q <= 1'b0;
      end else begin
        // the scl low after start is no bit; a stop may still follow
        if (scl_fall && cnt_q != 4'h0)
          just_start_q <= 1'b0;
        case (state_q)
          ST_ADDR, ST_RX: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_s};
              cnt_q <= cnt_q + 4'h1;
            end
            if (scl_fall && cnt_q == `TWS_BYTE_BITS) begin
              cnt_q <= 4'h0;
              hold_q <= 1'b1;
              if (state_q == ST_ADDR) begin
                if (addr_hit(shift_q[7:1], addr_q, mask_q)) begin
                  addr_if_q <= 1'b1; // [RULE2]
                  is_addr_q <= 1'b1;
                  dir_q <= shift_q[0]; // [RULE4]
                  state_q <= ST_ACK;
                end else begin
                  hold_q <= 1'b0;
                  state_q <= ST_IDLE; // [RULE1]
                end
              end else begin
                data_q <= shift_q;
                data_if_q <= 1'b1; // [RULE10] [RULE15]
                state_q <= ST_ACK;
              end
            end
          end
          ST_ACK: begin
            // software answers while scl is held
            if (!hold_q && !scl_s) begin
              drive_q <= ack_out_q;
              ack_phase_q <= 1'b1;
            end
            if (scl_fall && ack_phase_q) begin
              ack_phase_q <= 1'b0;
              if (!ack_out_q)
                state_q <= ST_IDLE; // [RULE6] [RULE10]
              else if (dir_q && is_addr_q) begin
                hold_q <= 1'b1;
                data_if_q <= 1'b1; // [RULE5]
                is_addr_q <= 1'b0;
                state_q <= ST_TX;
                drive_q <= 1'b0;
              end else begin
                is_addr_q <= 1'b0;
                drive_q <= 1'b0;
                state_q <= ST_RX; // [RULE7]
              end
            end
          end
          ST_TX: begin
            if (!hold_q && !scl_s && cnt_q != `TWS_BYTE_BITS)
              drive_q <= ~data_q[3'h7 - cnt_q[2:0]]; // [RULE11]
            if (scl_rise && cnt_q != `TWS_BYTE_BITS) begin
              if (!drive_q && !sda_s)
                coll_q <= 1'b1;
              cnt_q <= cnt_q + 4'h1;
            end
            if (scl_fall && cnt_q == `TWS_BYTE_BITS) begin
              drive_q <= 1'b0;
              cnt_q <= 4'h0;
              state_q <= ST_MACK;
            end
          end
          ST_MACK: begin
            if (scl_rise)
              ack_out_q <= ~sda_s;
            if (scl_fall) begin
              data_if_q <= 1'b1; // [RULE11] [RULE14]
              hold_q <= ~sda_q;
              state_q <= sda_q ? ST_WAIT : ST_TX; // [RULE12]
            end
          end
          ST_WAIT: drive_q <= 1'b0;
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end
endmodule

// ---- hw/tws_sync.v ----
// two flip-flop synchroniser for one pin
// assumes: input is asynchronous to i_clk
`timescale 1ns/1ps
module tws_sync (
  input wire i_clk,
  input wire i_reset,
  input wire i_ce,
  input wire i_pin,
  output reg o_level
);
  reg meta_q;
  always @(posedge i_clk) begin
    if (i_reset) begin
      meta_q <= 1'b1;
      o_level <= 1'b1;
    end else if (i_ce) begin
      meta_q <= i_pin;
      o_level <= meta_q;
    end
  end
endmodule

// ---- testbench/tb.sv ----
// bench: wishbone software side against a bus master model
// assumes: pull-ups on scl and sda, 100 ns core clock
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [31:0] adr = 32'h0000_0000;
  logic [31:0] wdat = 32'h0000_0000;
  wire [31:0] rdat;
  wire ack, scl_oe, sda_oe, m_scl_oe, m_sda_oe;
  wire scl = !(scl_oe || m_scl_oe);
  wire sda = !(sda_oe || m_sda_oe);
  integer fails = 0;
  integer check_count = 0;
  integer seed = 32'hb5d0;
  logic [7:0] q, d, rx;
  logic nk;
  always #50 clk = ~clk;
  tws_slave u_dut (.I_CORE_CLK(clk), .I_RESET(rst), .I_CE(1'b1), .I_WB_CYC(cyc),
    .I_WB_STB(stb), .I_WB_WE(we), .I_WB_SEL(4'hf), .I_WB_ADR(adr), .I_WB_DAT(wdat),
    .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_SCL(scl), .O_SCL(), .O_SCL_OE(scl_oe),
    .I_SDA(sda), .O_SDA(), .O_SDA_OE(sda_oe));
  tws_master u_mst (.i_scl(scl), .i_sda(sda), .o_scl_oe(m_scl_oe), .o_sda_oe(m_sda_oe));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic hang();
    fails++;
    $display("wait limit reached at %0t", $time);
    complete_run();
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request held until the rising edge that samples ack high, released there
  task automatic wb(input logic w, input logic [3:0] idx, input logic [7:0] v);
    integer n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {26'h0, idx, 2'h0};
    wdat <= {24'h00_0000, v};
    do @(posedge clk); while (ack !== 1'b1 && ++n < 50);
    if (ack !== 1'b1) hang();
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic poll(input logic [7:0] m, input logic [7:0] v);
    integer n;
    n = 0;
    do wb(1'b0, 4'h2, 8'h00); while ((q & m) !== v && ++n < 400);
    if ((q & m) !== v) hang();
  endtask
  function automatic logic hit(input logic [7:0] ab, input logic [7:0] msk);
    if (ab[7:1] == 7'h00) return 1'b1;
    if (msk[0]) return ab[7:1] == 7'h42 || ab[7:1] == msk[7:1];
    return ((ab[7:1] ^ 7'h42) & ~msk[7:1]) == 7'h00;
  endfunction
  task automatic talk(input logic [7:0] ab, input logic [7:0] msk);
    logic m;
    m = hit(ab, msk);
    d = 8'($random(seed));
    wb(1'b1, 4'h5, msk);
    u_mst.start();
    fork
      u_mst.wbyte(ab, nk);
      if (m) begin
        poll(8'h42, 8'h42);
        cmp(q[3], ab[0]);
        wb(1'b1, 4'h1, 8'h06);
      end
    join
    cmp(nk, !m);
    if (m && !ab[0]) fork
      u_mst.wbyte(d, nk);
      begin
        poll(8'h05, 8'h05);
        wb(1'b0, 4'h4, 8'h00);
        cmp(q, d);
        wb(1'b1, 4'h1, 8'h06);
      end
    join
    if (m && !ab[0]) cmp(nk, 1'b0);
    if (m && ab[0]) fork
      u_mst.rbyte(1'b1, rx);
      begin
        poll(8'h0d, 8'h0d);
        wb(1'b1, 4'h4, d);
      end
    join
    if (m && ab[0]) cmp(rx, d);
    // a hold after the master nack would block the stop
    fork
      u_mst.stop();
      if (m && ab[0]) begin
        wb(1'b0, 4'h2, 8'h00);
        wb(1'b0, 4'h2, 8'h00);
        if (q[2]) wb(1'b1, 4'h1, 8'h04);
      end
    join
    if (m) poll(8'h42, 8'h02);
    $display("transfer %h mask %h done", ab, msk);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wb(1'b1, 4'h3, 8'h84);
    wb(1'b1, 4'h0, 8'h01);
    wb(1'b0, 4'h3, 8'h00);
    cmp(q, 8'h84);
    wb(1'b0, 4'h7, 8'h00);
    cmp(q, 8'h00);
    wb(1'b0, 4'h4, 8'h00);
    cmp(q, 8'h00);
    talk(8'h84, 8'h00);
    talk(8'h26, 8'h00);
    talk(8'h86, 8'h02);
    talk(8'h8a, 8'h02);
    talk(8'h30, 8'h31);
    talk(8'h88, 8'h31);
    talk(8'h00, 8'h30);
    talk(8'h85, 8'h00);
    // auto mode: the data read itself answers, here with the nack choice
    d = 8'($random(seed)) | 8'h01;
    wb(1'b1, 4'h0, 8'h03);
    u_mst.start();
    fork
      u_mst.wbyte(8'h84, nk);
      begin
        poll(8'h42, 8'h42);
        wb(1'b1, 4'h1, 8'h06);
      end
    join
    cmp(nk, 1'b0);
    wb(1'b1, 4'h1, 8'h01);
    fork
      u_mst.wbyte(d, nk);
      begin
        poll(8'h05, 8'h05);
        wb(1'b0, 4'h4, 8'h00);
        cmp(q, d);
      end
    join
    cmp(nk, 1'b1);
    u_mst.stop();
    wb(1'b0, 4'h4, 8'h00);
    cmp(q, 8'h00);
    $display("auto answer test done");
    u_mst.start();
    u_mst.stop();
    poll(8'h20, 8'h20);
    wb(1'b1, 4'h2, 8'h20);
    wb(1'b0, 4'h2, 8'h00);
    cmp(q[5], 1'b0);
    complete_run();
  end
  initial begin
    #5_000_000;
    hang();
  end
endmodule

// ---- testbench/tws_master.sv ----
// two-wire bus master model, open-drain enables only
// assumes: wires formed outside with pull-ups, 800 ns bit
`timescale 1ns/1ps
module tws_master (
  input wire i_scl,
  input wire i_sda,
  output logic o_scl_oe,
  output logic o_sda_oe
);
  initial begin
    o_scl_oe = 1'b0;
    o_sda_oe = 1'b0;
  end
  // slave may stretch; bounded so a stuck hold cannot hang us
  task automatic high();
    integer i;
    o_scl_oe = 1'b0;
    for (i = 0; i < 3000 && !i_scl; i++) #100;
    #400;
  endtask
  // sda moves 100 ns after scl falls, never with it
  task automatic bitx(input logic b, output logic r);
    o_sda_oe = !b;
    #300;
    high();
    r = i_sda;
    o_scl_oe = 1'b1;
    #100;
  endtask
  task automatic start();
    o_sda_oe = 1'b0;
    #300;
    high();
    o_sda_oe = 1'b1;
    #400;
    o_scl_oe = 1'b1;
    #100;
  endtask
  task automatic stop();
    o_sda_oe = 1'b1;
    #300;
    high();
    o_sda_oe = 1'b0;
    #400;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(b[i], r);
    bitx(1'b1, nack);
  endtask
  task automatic rbyte(input logic nack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, b[i]);
    bitx(nack, r);
  endtask
endmodule

// ---- testbench/tws_props.sv ----
// port checker for the two-wire slave engine
// assumes: bound into tws_slave, one clock domain
`timescale 1ns/1ps
module tws_props (
  input wire I_CORE_CLK,
  input wire I_RESET,
  input wire I_CE,
  input wire I_WB_CYC,
  input wire I_WB_STB,
  input wire I_WB_WE,
  input wire [31:0] I_WB_ADR,
  input wire [31:0] O_WB_DAT,
  input wire O_WB_ACK,
  input wire I_SCL,
  input wire O_SCL_OE,
  input wire O_SDA_OE
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RESET);
  wire req = I_WB_CYC && I_WB_STB && !O_WB_ACK;
  wire [3:0] idx = I_WB_ADR[5:2];
  ack_pulse_a: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack longer than one cycle");
  ack_time_a: assert property (req && I_CE |=> O_WB_ACK)
    else $error("request not acked");
  ack_cause_a: assert property ($rose(O_WB_ACK) |-> $past(req))
    else $error("ack without request");
  high_zero_a: assert property (O_WB_ACK |-> O_WB_DAT[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  gap_zero_a: assert property (req && !I_WB_WE && idx > 4'h5 |=> O_WB_DAT == 32'h0000_0000)
    else $error("unmapped read not zero");
  data_lock_a: assert property (
    req && !I_WB_WE && idx == 4'h4 && !O_SCL_OE |=> O_WB_DAT == 32'h0000_0000)
    else $error("data read while bus busy");
  hold_free_a: assert property (
    req && I_WB_WE && idx == 4'h4 && O_SCL_OE |-> ##[1:4] !O_SCL_OE)
    else $error("clock hold kept after data write");
  // sync delay: only judge once scl has been high for three samples
  sda_still_a: assert property (I_SCL && $past(I_SCL) && $past(I_SCL, 2) |-> $stable(O_SDA_OE))
    else $error("sda moved while scl high");
  rst_idle_a: assert property (disable iff (1'b0)
    I_RESET |=> !O_SCL_OE && !O_SDA_OE && !O_WB_ACK)
    else $error("outputs active in reset");
endmodule
bind tws_slave tws_props u_props (.I_CORE_CLK(I_CORE_CLK), .I_RESET(I_RESET), .I_CE(I_CE),
  .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR),
  .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .I_SCL(I_SCL), .O_SCL_OE(O_SCL_OE),
  .O_SDA_OE(O_SDA_OE));
